// [lbst_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Contract
// - 16-bit counter counts on clock when enabled
// - overflow raises maskable interrupt
// - first register captures count on rx fall
// - compare mode flags match with running count
// - second register captures count on rx rise
// - separate maskable rise and fall interrupts
// - both select bits set means compare only
// - break bit forces transmit output low
// - checksum adds carry back, then inverts
// - classic data only, enhanced adds identifier
// - low-only option counts while rx low
// - zero-on-fall option clears count on fall while counter enabled
// - rise capture only when its enable set
module lbst_top
   import lbst_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // lin line
   input  wire logic        rxd,
   input  wire logic        uart_txd,
   output logic             txd,
   // interrupt
   output logic             irq
);

   // =====================================================================
   // bus decode
   lbst_apb_req_type req;
   logic wr_en;
   logic rd_en;
   logic hit_ctl;
   logic hit_cnt;
   logic hit_fall;
   logic hit_rise;
   logic hit_stat;
   logic hit_mask;
   logic hit_ck;
   logic hit_any;

   assign req      = '{sel: psel, enable: penable, write: pwrite,
                       addr: paddr, wdata: pwdata};
   assign wr_en    = req.sel && req.enable && req.write;
   // read data is staged in the setup cycle, so it stands in access
   assign rd_en    = req.sel && !req.enable && !req.write;
   assign hit_ctl  = req.addr == LBST_ADDR_CTL;
   assign hit_cnt  = req.addr == LBST_ADDR_CNT;
   assign hit_fall = req.addr == LBST_ADDR_FALLREG;
   assign hit_rise = req.addr == LBST_ADDR_RISEREG;
   assign hit_stat = req.addr == LBST_ADDR_STAT;
   assign hit_mask = req.addr == LBST_ADDR_MASK;
   assign hit_ck   = req.addr == LBST_ADDR_CKSUM;
   assign hit_any  = hit_ctl | hit_cnt | hit_fall | hit_rise |
                     hit_stat | hit_mask | hit_ck;
   // zero wait states keeps software timing loops predictable
   assign pready   = 1'b1;
   assign pslverr  = req.sel && req.enable && !hit_any;

   // =====================================================================
   // control
   logic [LBST_CTL_WIDTH-1:0] ctl;
   lbst_ctl_type              c;

   assign c.ena   = ctl[LBST_CTL_ENA];
   assign c.low   = ctl[LBST_CTL_LOW];
   assign c.zero  = ctl[LBST_CTL_ZERO];
   assign c.rcap  = ctl[LBST_CTL_RCAP];
   assign c.fcap  = ctl[LBST_CTL_FCAP];
   assign c.match = ctl[LBST_CTL_MATCH];
   assign c.break_force_bit   = ctl[LBST_CTL_BRK];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= '0;
      end else if (wr_en && hit_ctl) begin
         ctl <= pwdata[LBST_CTL_WIDTH-1:0];
      end
   end

   // =====================================================================
   // receive edge detection (rxd synchronous to pclk)
   logic rx_prev;
   logic rx_fall;
   logic rx_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_prev <= 1'b1;
      end else begin
         rx_prev <= rxd;
      end
   end

   assign rx_fall = rx_prev && !rxd;
   assign rx_rise = !rx_prev && rxd;

   // =====================================================================
   // timing counter
   logic [LBST_CNT_W-1:0] cnt;
   logic [LBST_CNT_W-1:0] next_cnt;
   logic                  cnt_step;
   logic                  cnt_ovf;
   logic                  cnt_wr;
   logic                  cnt_clr;

   // low-only option gates the step while the line idles high
   assign cnt_step = c.ena && (!c.low || !rxd);
   assign cnt_wr   = wr_en && hit_cnt;
   assign cnt_clr  = c.ena && c.zero && rx_fall;
   // a load or a zeroing in the wrap cycle is not an overflow
   assign cnt_ovf  = cnt_step && !cnt_wr && !cnt_clr &&
                     (cnt == LBST_CNT_MAX);
   assign next_cnt = cnt + 16'h0001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= LBST_ZERO16;
      end else if (cnt_wr) begin
         cnt <= pwdata[LBST_CNT_W-1:0];
      end else if (cnt_clr) begin
         cnt <= LBST_ZERO16;
      end else if (cnt_step) begin
         cnt <= next_cnt;
      end
   end

   // =====================================================================
   // capture / compare registers
   logic [LBST_CNT_W-1:0] fall_reg;
   logic [LBST_CNT_W-1:0] rise_reg;
   logic                  cmp_mode;
   logic                  fall_cap;
   logic                  rise_cap;
   logic                  match_hit;

   // compare overrides capture when both selects are set
   assign cmp_mode  = c.match;
   assign fall_cap  = c.fcap && !cmp_mode && rx_fall;
   assign rise_cap  = c.rcap && rx_rise;
   assign match_hit = cmp_mode && c.ena && (cnt == fall_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_reg <= LBST_ZERO16;
      end else if (fall_cap) begin
         fall_reg <= cnt;
      end else if (wr_en && hit_fall) begin
         fall_reg <= pwdata[LBST_CNT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_reg <= LBST_ZERO16;
      end else if (rise_cap) begin
         rise_reg <= cnt;
      end
   end

   // =====================================================================
   // events, status and mask
   logic [LBST_EV_WIDTH-1:0] ev;
   logic [LBST_EV_WIDTH-1:0] stat;
   logic [LBST_EV_WIDTH-1:0] mask;
   logic [LBST_EV_WIDTH-1:0] clr;

   assign clr = (wr_en && hit_stat) ? pwdata[LBST_EV_WIDTH-1:0] : '0;

   assign ev[LBST_EV_OVF]   = cnt_ovf;
   assign ev[LBST_EV_FCAP]  = fall_cap;
   assign ev[LBST_EV_MATCH] = match_hit;
   assign ev[LBST_EV_RCAP]  = rise_cap;
   assign ev[LBST_EV_RISE]  = rx_rise;
   assign ev[LBST_EV_FALL]  = rx_fall;

   // write-one-to-clear; a new event in the same cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < LBST_EV_WIDTH; gi++) begin : g_ev
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat[gi] <= 1'b0;
            end else if (ev[gi]) begin
               stat[gi] <= 1'b1;
            end else if (clr[gi]) begin
               stat[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= '0;
      end else if (wr_en && hit_mask) begin
         mask <= pwdata[LBST_EV_WIDTH-1:0];
      end
   end

   assign irq = |(stat & mask);

   // =====================================================================
   // break forcing on transmit
   // break length is purely software timed; no hardware minimum
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd <= 1'b1;
      end else begin
         txd <= uart_txd && !c.break_force_bit;
      end
   end

   // =====================================================================
   // checksum helper; software feeds identifier first for enhanced
   logic       ck_add;
   logic       ck_clear;
   logic [7:0] ck_sum;
   logic [7:0] ck_val;

   assign ck_add   = wr_en && hit_ck && !pwdata[LBST_CK_CLEAR];
   assign ck_clear = wr_en && hit_ck && pwdata[LBST_CK_CLEAR];

   lbst_cksum u_cksum (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (ck_clear),
      .add      (ck_add),
      .byte_in  (pwdata[LBST_CK_DATA +: 8]),
      .sum      (ck_sum),
      .checksum (ck_val)
   );

   // =====================================================================
   // read data
   logic [31:0] rd_mux;

   assign rd_mux = hit_ctl  ? {25'h0, ctl} :
                   hit_cnt  ? {16'h0, cnt} :
                   hit_fall ? {16'h0, fall_reg} :
                   hit_rise ? {16'h0, rise_reg} :
                   hit_stat ? {26'h0, stat} :
                   hit_mask ? {26'h0, mask} :
                   hit_ck   ? {16'h0, ck_sum, ck_val} : LBST_RD_ZERO;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= LBST_RD_ZERO;
      end else if (rd_en) begin
         prdata <= rd_mux;
      end
   end

   // =====================================================================
   // checks
   chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_step && !(wr_en && hit_cnt) && !(c.zero && rx_fall)
      |=> cnt == $past(cnt) + 16'h0001)
      else $error("counter did not step");

   chk_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_ovf |=> stat[LBST_EV_OVF])
      else $error("overflow not flagged");

   chk_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_ovf && !(wr_en && hit_cnt) |=> cnt == LBST_ZERO16)
      else $error("counter did not wrap");

   chk_fall_capture: assert property (@(posedge pclk) disable iff (!presetn)
      fall_cap |=> fall_reg == $past(cnt))
      else $error("fall capture missed");

   chk_match_irq: assert property (@(posedge pclk) disable iff (!presetn)
      match_hit ##1 mask[LBST_EV_MATCH] |-> irq)
      else $error("match interrupt missing");

   chk_rise_capture: assert property (@(posedge pclk) disable iff (!presetn)
      rx_rise && c.rcap |=> rise_reg == $past(cnt))
      else $error("rise capture missed");

   chk_rise_gated: assert property (@(posedge pclk) disable iff (!presetn)
      !c.rcap |=> $stable(rise_reg))
      else $error("rise capture without enable");

   chk_edge_flags: assert property (@(posedge pclk) disable iff (!presetn)
      rx_fall |=> stat[LBST_EV_FALL] && !$past(rx_rise))
      else $error("fall edge not flagged");

   chk_match_only: assert property (@(posedge pclk) disable iff (!presetn)
      c.match && c.fcap && rx_fall && !(wr_en && hit_fall)
      |=> $stable(fall_reg))
      else $error("capture despite compare mode");

   sequence s_brk_held;
      c.break_force_bit ##1 c.break_force_bit;
   endsequence
   chk_break_low: assert property (@(posedge pclk) disable iff (!presetn)
      s_brk_held |-> !txd)
      else $error("break not driving low");

   chk_low_only: assert property (@(posedge pclk) disable iff (!presetn)
      c.low && rxd && !(wr_en && hit_cnt) |=> cnt == $past(cnt)
         || cnt == LBST_ZERO16)
      else $error("counted while line high");

   chk_fall_zero: assert property (@(posedge pclk) disable iff (!presetn)
      c.ena && c.zero && rx_fall && !(wr_en && hit_cnt)
      |=> cnt == LBST_ZERO16)
      else $error("fall did not zero counter");

   chk_rise_flag: assert property (@(posedge pclk) disable iff (!presetn)
      rx_rise |=> stat[LBST_EV_RISE])
      else $error("rise edge not flagged");

   chk_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
      match_hit |=> stat[LBST_EV_MATCH])
      else $error("match not flagged");

   chk_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !cnt_step && !cnt_wr && !cnt_clr |=> $stable(cnt))
      else $error("counter moved while stopped");

   chk_txd_follow: assert property (@(posedge pclk) disable iff (!presetn)
      !c.break_force_bit |=> txd == $past(uart_txd))
      else $error("transmit path altered without break");

endmodule
`default_nettype wire

// [lbst_pkg.sv]
package lbst_pkg;

   // =====================================================================
   // register map (byte addresses, one aligned word each)
   localparam logic [7:0] LBST_ADDR_CTL     = 8'h00;
   localparam logic [7:0] LBST_ADDR_CNT     = 8'h04;
   localparam logic [7:0] LBST_ADDR_FALLREG = 8'h08;
   localparam logic [7:0] LBST_ADDR_RISEREG = 8'h0c;
   localparam logic [7:0] LBST_ADDR_STAT    = 8'h10;
   localparam logic [7:0] LBST_ADDR_MASK    = 8'h14;
   localparam logic [7:0] LBST_ADDR_CKSUM   = 8'h18;

   // =====================================================================
   // control field positions
   localparam int LBST_CTL_ENA    = 0;
   localparam int LBST_CTL_LOW    = 1;
   localparam int LBST_CTL_ZERO   = 2;
   localparam int LBST_CTL_RCAP   = 3;
   localparam int LBST_CTL_FCAP   = 4;
   localparam int LBST_CTL_MATCH  = 5;
   localparam int LBST_CTL_BRK    = 6;
   localparam int LBST_CTL_WIDTH  = 7;

   // =====================================================================
   // event bit positions in status and mask
   localparam int LBST_EV_OVF   = 0;
   localparam int LBST_EV_FCAP  = 1;
   localparam int LBST_EV_MATCH = 2;
   localparam int LBST_EV_RCAP  = 3;
   localparam int LBST_EV_RISE  = 4;
   localparam int LBST_EV_FALL  = 5;
   localparam int LBST_EV_WIDTH = 6;

   // =====================================================================
   // checksum command bits (write to checksum register)
   localparam int LBST_CK_DATA  = 0;
   localparam int LBST_CK_CLEAR = 8;

   // =====================================================================
   // widths and reset values
   localparam int          LBST_CNT_W   = 16;
   localparam logic [15:0] LBST_CNT_MAX = 16'hffff;
   localparam logic [15:0] LBST_ZERO16  = 16'h0000;
   localparam logic [7:0]  LBST_CK_INIT = 8'h00;
   localparam logic [31:0] LBST_RD_ZERO = 32'h0000_0000;

   // =====================================================================
   // apb request bundle
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } lbst_apb_req_type;

   typedef struct packed {
      logic                     ena;
      logic                     low;
      logic                     zero;
      logic                     rcap;
      logic                     fcap;
      logic                     match;
      logic                     break_force_bit;
   } lbst_ctl_type;

endpackage

// [lbst_cksum.sv]
`timescale 1ns/100ps
`default_nettype none
module lbst_cksum
   import lbst_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // byte stream
   input  wire logic       clear,
   input  wire logic       add,
   input  wire logic [7:0] byte_in,
   // result
   output logic      [7:0] sum,
   output logic      [7:0] checksum
);

   // =====================================================================
   // end-around carry accumulator
   logic [8:0] raw_sum;
   logic [7:0] next_sum;

   assign raw_sum  = {1'b0, sum} + {1'b0, byte_in};
   // carry folded back in, never overflows again
   assign next_sum = raw_sum[7:0] + {7'h00, raw_sum[8]};
   assign checksum = ~sum;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum <= LBST_CK_INIT;
      end else if (clear) begin
         sum <= LBST_CK_INIT;
      end else if (add) begin
         sum <= next_sum;
      end
   end

   chk_carry_fold: assert property (@(posedge pclk) disable iff (!presetn)
      add && !clear |=> sum == $past(next_sum))
      else $error("checksum accumulate wrong");

endmodule
`default_nettype wire

// [lbst_lin_node.sv]
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// lin bus node seen through the transceiver
module lbst_lin_node (
   // clock
   input  wire logic        pclk,
   // bus lines
   input  wire logic        txd,
   output logic             rxd,
   // dominant stretches seen on txd
   output logic [15:0]      low_run,
   output logic [15:0]      last_low
);
   // recessive bus is pulled high, so idle shows 1
   initial rxd = 1'b1;
   initial low_run = 16'h0000;
   initial last_low = 16'h0000;

   // =====================================================================
   // break length as the bus sees it
   always @(posedge pclk) begin
      if (txd === 1'b0) begin
         low_run <= low_run + 16'h0001;
      end else begin
         if (low_run != 16'h0000) begin
            last_low <= low_run;
         end
         low_run <= 16'h0000;
      end
   end

   // =====================================================================
   // dominant pulse of n clocks, like a break or a sync bit
   task automatic drive_low(input int n);
      @(posedge pclk);
      rxd <= 1'b0;
      repeat (n) @(posedge pclk);
      rxd <= 1'b1;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("unexpected at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module tb_top;
   import lbst_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxd;
   logic        uart_txd;
   logic        txd;
   logic        irq;
   logic [15:0] low_run;
   logic [15:0] last_low;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  s;
   logic [8:0]  t;
   int          n;
   int          m;
   int          k;
   int          bad_count = 0;
   int          compares = 0;
   logic [7:0]  frame [6] = '{8'h0d, 8'hab, 8'hbc, 8'hcd, 8'hde, 8'hef};

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   lbst_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
      .uart_txd(uart_txd), .txd(txd), .irq(irq));

   lbst_lin_node u_node (.pclk(pclk), .txd(txd), .rxd(rxd),
      .low_run(low_run), .last_low(last_low));

   // =====================================================================
   // closing and bus tasks
   task automatic final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   function automatic logic [31:0] bv(input int p);
      return 32'h1 << p;
   endfunction

   // slave answer time is not assumed, only bounded
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         bad_count++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask

   task automatic wait_irq;
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n == 300) begin
         bad_count++;
         final_report();
      end
   endtask

   // =====================================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      uart_txd = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(LBST_ADDR_STAT, 32'h0);
      `CHK(txd, 1'b1)
      apb(1'b0, 8'h1c, 32'h0);
      `CHK({err, rd}, 33'h1_0000_0000)
      // captures with the counter stopped give exact values
      wr(LBST_ADDR_CTL, bv(LBST_CTL_FCAP) | bv(LBST_CTL_RCAP));
      wr(LBST_ADDR_CNT, 32'h1234);
      u_node.drive_low(6);
      rdchk(LBST_ADDR_FALLREG, 32'h1234);
      rdchk(LBST_ADDR_RISEREG, 32'h1234);
      rdchk(LBST_ADDR_STAT, 32'h3a);
      wr(LBST_ADDR_MASK, bv(LBST_EV_RISE));
      @(negedge pclk);
      `CHK(irq, 1'b1)
      wr(LBST_ADDR_STAT, 32'h3f);
      @(negedge pclk);
      `CHK(irq, 1'b0)
      wr(LBST_ADDR_CTL, bv(LBST_CTL_FCAP));
      wr(LBST_ADDR_CNT, 32'h0077);
      u_node.drive_low(6);
      rdchk(LBST_ADDR_FALLREG, 32'h0077);
      rdchk(LBST_ADDR_RISEREG, 32'h1234);
      // timed break ended from the match interrupt
      wr(LBST_ADDR_MASK, bv(LBST_EV_MATCH));
      wr(LBST_ADDR_STAT, 32'h3f);
      wr(LBST_ADDR_FALLREG, 32'h0040);
      wr(LBST_ADDR_CNT, 32'h0);
      // break is set before any byte reaches the transmitter
      wr(LBST_ADDR_CTL, 32'h71);
      wait_irq();
      `CHK(n >= 63 && n <= 68, 1'b1)
      `CHK(txd, 1'b0)
      `CHK(low_run >= 16'd60 && low_run <= 16'd68, 1'b1)
      wr(LBST_ADDR_CTL, 32'h31);
      repeat (3) @(posedge pclk);
      `CHK(txd, 1'b1)
      `CHK(last_low >= 16'd64 && last_low <= 16'd76, 1'b1)
      u_node.drive_low(4);
      rdchk(LBST_ADDR_FALLREG, 32'h0040);
      uart_txd <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(txd, 1'b0)
      uart_txd <= 1'b1;
      // overflow, wrap and mask
      wr(LBST_ADDR_CTL, 32'h0);
      wr(LBST_ADDR_STAT, 32'h3f);
      wr(LBST_ADDR_MASK, bv(LBST_EV_OVF));
      wr(LBST_ADDR_CNT, 32'hfff0);
      wr(LBST_ADDR_CTL, bv(LBST_CTL_ENA));
      wait_irq();
      `CHK(n >= 15 && n <= 20, 1'b1)
      wr(LBST_ADDR_CTL, 32'h0);
      apb(1'b0, LBST_ADDR_CNT, 32'h0);
      `CHK(rd < 32'h20, 1'b1)
      wr(LBST_ADDR_MASK, 32'h0);
      @(negedge pclk);
      `CHK(irq, 1'b0)
      rdchk(LBST_ADDR_STAT, bv(LBST_EV_OVF));
      // low-only counting from a zero on the falling edge
      wr(LBST_ADDR_CNT, 32'h0500);
      wr(LBST_ADDR_CTL, 32'h0f);
      repeat (10) @(posedge pclk);
      rdchk(LBST_ADDR_CNT, 32'h0500);
      u_node.drive_low(30);
      apb(1'b0, LBST_ADDR_RISEREG, 32'h0);
      `CHK(rd >= 32'd27 && rd <= 32'd32, 1'b1)
      // zeroing waits for the enable
      wr(LBST_ADDR_CTL, 32'h06);
      wr(LBST_ADDR_CNT, 32'h0500);
      u_node.drive_low(5);
      rdchk(LBST_ADDR_CNT, 32'h0500);
      // responder break detect, threshold 9.5 bits at two clocks a bit
      wr(LBST_ADDR_STAT, 32'h3f);
      wr(LBST_ADDR_CNT, 32'h0);
      wr(LBST_ADDR_FALLREG, 32'h0013);
      wr(LBST_ADDR_MASK, bv(LBST_EV_MATCH));
      wr(LBST_ADDR_CTL, 32'h27);
      u_node.drive_low(10);
      rdchk(LBST_ADDR_STAT, 32'h30);
      `CHK(irq, 1'b0)
      u_node.drive_low(30);
      rdchk(LBST_ADDR_STAT, 32'h34);
      `CHK(irq, 1'b1)
      // enhanced sum first, then classic without identifier
      for (m = 0; m < 2; m++) begin
         wr(LBST_ADDR_CKSUM, bv(LBST_CK_CLEAR));
         s = LBST_CK_INIT;
         for (k = m; k < 6; k++) begin
            wr(LBST_ADDR_CKSUM, {24'h0, frame[k]});
            t = {1'b0, s} + {1'b0, frame[k]};
            s = t[7:0] + {7'h0, t[8]};
         end
         rdchk(LBST_ADDR_CKSUM, {16'h0, s, ~s});
         // worked enhanced frame: sum 0x12, checksum 0xed
         if (m == 0) `CHK(rd[15:0], 16'h12ed)
      end
      final_report();
   end
endmodule
`default_nettype wire
